//--- dv/eic_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
// ========================================
// Bench top.
module eic_ctrl_bench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr = 1'b0;
    logic rdn = 1'b0;
    logic [15:0] ad = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic [8:0] lvl = 9'h000;
    logic [15:0] v;
    logic [15:0] w;
    logic [7:0] e;
    wire [15:0] rdat;
    wire [8:0] pin;
    wire [8:0] irq;
    wire [7:0] n_ch;
    wire [7:0] n_nmi;
    wire [7:0] n_c13;
    wire irq_o;
    int miscompares = 0;
    int total_checks = 0;
    always #4 clk_i = ~clk_i;
    eic_ctrl eic_ctrl_inst (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(ad), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rdn), .reg_rdata_o(rdat), .ext_irq_channel_i(pin[6:0]),
        .ext_nonmaskable_irq_i(pin[7]), .timer1_irq_i(pin[8]), .ext_irq_channel_o(irq[6:0]),
        .ext_nonmaskable_irq_o(irq[7]), .cpu_irq_thirteen_o(irq[8]), .irq_o(irq_o));
    eic_pin_model eic_pin_model_inst (.clk_i(clk_i), .srst_i(srst_i), .lvl_i(lvl),
        .irq_i(irq), .pin_o(pin), .n_ch_o(n_ch), .n_nmi_o(n_nmi), .n_c13_o(n_c13));
    task wrt(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        @(negedge clk_i);
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk_i);
        ad <= a;
        rdn <= 1'b1;
        @(posedge clk_i);
        rdn <= 1'b0;
        @(negedge clk_i);
        v = rdat;
    endtask
    task pins(input logic [8:0] l);
        @(posedge clk_i);
        lvl <= l;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task t_regs;
        for (int a = 16'h7060; a <= 16'h7081; a++) begin
            rd(16'(a));
            `CHK(v, 16'h0000)
        end
        for (int n = 0; n < 7; n++) begin
            wrt(16'h7060 + 16'(n), 16'hFFFF);
            rd(16'h7060 + 16'(n));
            `CHK(v, 16'h000D)
            wrt(16'h7060 + 16'(n), 16'h0000);
        end
        rd(16'h7078);
        w = v;
        wrt(16'h7078, 16'h1234);
        wrt(16'h7067, 16'hFFFF);
        rd(16'h7078);
        `CHK(v, w)
        rd(16'h7067);
        `CHK(v, 16'h0000)
        $display("t_regs done");
    endtask
    task t_pol;
        e = n_ch;
        for (int p = 0; p < 4; p++) begin
            wrt(16'h7060 + 16'(p), 16'(p * 4 + 1));
            pins(9'h001 << p);
            e += 8'(p % 2);
            `CHK(n_ch, e)
            pins(9'h000);
            e += 8'(p != 1);
            `CHK(n_ch, e)
        end
        pins(9'h010);
        pins(9'h000);
        `CHK(n_ch, e)
        wrt(16'h7066, 16'h0005);
        pins(9'h040);
        `CHK(n_ch, e + 8'h01)
        $display("t_pol done");
    endtask
    task t_cnt;
        rd(16'h7079);
        w = v;
        repeat (9) @(posedge clk_i);
        rd(16'h7079);
        `CHK(v - w, 16'h000B)
        pins(9'h002);
        rd(16'h7079);
        `CHK(v < 16'h0010, 1'b1)
        wrt(16'h7061, 16'h0004);
        rd(16'h7079);
        w = v;
        repeat (9) @(posedge clk_i);
        rd(16'h7079);
        `CHK(v, w)
        $display("t_cnt done");
    endtask
    task t_irq;
        wrt(16'h7080, 16'h00FF);
        wrt(16'h7081, 16'h0001);
        pins(9'h003);
        `CHK(irq_o, 1'b0)
        pins(9'h002);
        `CHK(irq_o, 1'b1)
        rd(16'h7080);
        `CHK(v, 16'h0001)
        wrt(16'h7081, 16'h0000);
        `CHK(irq_o, 1'b0)
        wrt(16'h7081, 16'h0001);
        `CHK(irq_o, 1'b1)
        wrt(16'h7080, 16'h0001);
        `CHK(irq_o, 1'b0)
        $display("t_irq done");
    endtask
    task t_nmi;
        wrt(16'h7077, 16'h0005);
        e = n_c13;
        pins(9'h080);
        `CHK(n_nmi, 8'h01)
        pins(9'h180);
        pins(9'h080);
        `CHK(n_c13, e + 8'h09)
        wrt(16'h7077, 16'h0007);
        pins(9'h000);
        pins(9'h080);
        `CHK(n_c13, e + 8'h0A)
        pins(9'h180);
        pins(9'h080);
        `CHK(n_c13, e + 8'h0A)
        `CHK(n_nmi, 8'h01)
        rd(16'h7077);
        `CHK(v, 16'h0007)
        $display("t_nmi done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        t_regs;
        t_pol;
        t_cnt;
        t_irq;
        t_nmi;
        give_verdict;
    end
    initial begin
        #400000;
        miscompares++;
        give_verdict;
    end
endmodule // eic_ctrl_bench
`default_nettype wire

//--- dv/eic_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Port-level properties.
module eic_ctrl_monitor #(
    parameter NUM_CHAN = 7
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic timer1_irq_i,
    input wire logic [NUM_CHAN-1:0] ext_irq_channel_o,
    input wire logic ext_nonmaskable_irq_o,
    input wire logic cpu_irq_thirteen_o,
    input wire logic irq_o
);
    logic sel_q;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // A shadow of the select bit keeps the checker blind to the design internals.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sel_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == 16'h7077) begin
            sel_q <= reg_wdata_i[1];
        end
    end
    property p_idle; !reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_rsvd; reg_rd_i && reg_addr_i inside {[16'h7060:16'h7066]} |=>
        reg_rdata_o[15:4] == 12'h000 && !reg_rdata_o[1]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_hole; reg_rd_i && reg_addr_i == 16'h7067 |=> reg_rdata_o == 16'h0000; endproperty
    a_hole: assert property (p_hole) else $error("hole reads nonzero");
    property p_chp; ext_irq_channel_o != '0 |=>
        (ext_irq_channel_o & $past(ext_irq_channel_o)) == '0; endproperty
    a_chp: assert property (p_chp) else $error("channel pulse too long");
    property p_nmp; ext_nonmaskable_irq_o |=> !ext_nonmaskable_irq_o; endproperty
    a_nmp: assert property (p_nmp) else $error("nmi pulse too long");
    property p_mask; reg_wr_i && reg_addr_i == 16'h7081 && reg_wdata_i == 16'h0000
        |-> ##2 !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("irq with mask off");
    property p_tmr; !sel_q && !$past(sel_q) |->
        cpu_irq_thirteen_o == $past(timer1_irq_i); endproperty
    a_tmr: assert property (p_tmr) else $error("timer not routed");
    property p_nsel; ext_nonmaskable_irq_o |-> !sel_q || !$past(sel_q); endproperty
    a_nsel: assert property (p_nsel) else $error("nmi while pin selected");
endmodule // eic_ctrl_monitor
bind eic_ctrl eic_ctrl_monitor #(.NUM_CHAN(NUM_CHAN)) eic_ctrl_monitor_inst (.clk_i(clk_i),
    .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .timer1_irq_i(timer1_irq_i),
    .ext_irq_channel_o(ext_irq_channel_o), .ext_nonmaskable_irq_o(ext_nonmaskable_irq_o),
    .cpu_irq_thirteen_o(cpu_irq_thirteen_o), .irq_o(irq_o));
`default_nettype wire

//--- dv/eic_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Pins and CPU side: drives levels, counts high cycles.
module eic_pin_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [8:0] lvl_i,
    input wire logic [8:0] irq_i,
    output logic [8:0] pin_o,
    output logic [7:0] n_ch_o,
    output logic [7:0] n_nmi_o,
    output logic [7:0] n_c13_o
);
    // Counting cycles, not rises, exposes a pulse that lingers.
    always @(posedge clk_i) begin
        pin_o <= lvl_i;
        n_ch_o <= srst_i ? 8'h00 : n_ch_o + 8'(|irq_i[6:0]);
        n_nmi_o <= srst_i ? 8'h00 : n_nmi_o + 8'(irq_i[7]);
        n_c13_o <= srst_i ? 8'h00 : n_c13_o + 8'(irq_i[8]);
    end
endmodule // eic_pin_model
`default_nettype wire

//--- verilog/eic_channel.v
`timescale 1ns/10ps
`default_nettype none

`include "eic_defines.vh"

module eic_channel #(
    parameter CNT_W = `EIC_CNT_W
) (
    input wire clk_i,
    input wire srst_i,
    input wire pin_i,
    input wire en_i,
    input wire [1:0] pol_i,
    output reg edge_o,
    output reg [CNT_W-1:0] cnt_o
);

    // ======================================================================
    // Pin synchroniser and previous level
    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    reg hit;

    always @(posedge clk_i) begin
        if (srst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ======================================================================
    // Edge selection by polarity
    always @* begin
        case (pol_i)
            `EIC_POL_RISE: hit = sync2_q & ~prev_q;
            `EIC_POL_BOTH: hit = sync2_q ^ prev_q;
            default: hit = ~sync2_q & prev_q;
        endcase
    end

    // ======================================================================
    // Event pulse and timestamp counter
    // A disabled channel neither raises events nor counts, so the counter
    // holds the age of the last edge seen while enabled.
    always @(posedge clk_i) begin
        if (srst_i) begin
            edge_o <= 1'b0;
            cnt_o <= {CNT_W{1'b0}};
        end else begin
            edge_o <= en_i & hit;
            if (en_i & hit) begin
                cnt_o <= {CNT_W{1'b0}};
            end else if (en_i) begin
                cnt_o <= cnt_o + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // eic_channel

`default_nettype wire

//--- verilog/eic_ctrl.v
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

`include "eic_defines.vh"

module eic_ctrl #(
    parameter NUM_CHAN = `EIC_NUM_CHAN,
    parameter CNT_W = `EIC_CNT_W
) (
    input wire clk_i,
    input wire srst_i,
    // Register port.
    input wire [`EIC_ADDR_W-1:0] reg_addr_i,
    input wire [`EIC_DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [`EIC_DATA_W-1:0] reg_rdata_o,
    // Pins, asynchronous to clk_i.
    input wire [NUM_CHAN-1:0] ext_irq_channel_i,
    input wire ext_nonmaskable_irq_i,
    // Internal timer one request, same clock domain.
    input wire timer1_irq_i,
    // CPU side.
    output reg [NUM_CHAN-1:0] ext_irq_channel_o,
    output reg ext_nonmaskable_irq_o,
    output reg cpu_irq_thirteen_o,
    output reg irq_o
);

    localparam NCH = NUM_CHAN + 1;
    localparam NMI = NUM_CHAN;

    // ======================================================================
    // Helper functions
    function [`EIC_DATA_W-1:0] fmt_ctrl;
        input [1:0] pol;
        input en;
        input sel;
        begin
            fmt_ctrl = `EIC_CTRL_RST;
            fmt_ctrl[`EIC_POL_HI:`EIC_POL_LO] = pol;
            fmt_ctrl[`EIC_SEL_BIT] = sel;
            fmt_ctrl[`EIC_EN_BIT] = en;
        end
    endfunction

    function [`EIC_ADDR_W-1:0] ctrl_addr;
        input integer k;
        integer t;
        begin
            t = `EIC_CTRL_BASE + k;
            ctrl_addr = t[`EIC_ADDR_W-1:0];
        end
    endfunction

    function [`EIC_ADDR_W-1:0] cnt_addr;
        input integer k;
        integer t;
        begin
            t = `EIC_CNT_BASE + k;
            if (k == 0) begin
                cnt_addr = `EIC_CNT1_ADDR;
            end else if (k == 1) begin
                cnt_addr = `EIC_CNT2_ADDR;
            end else begin
                cnt_addr = t[`EIC_ADDR_W-1:0];
            end
        end
    endfunction

    // ======================================================================
    // Control state
    reg [2*NCH-1:0] pol_q;
    reg [2*NCH-1:0] pol_d;
    reg [NCH-1:0] en_q;
    reg [NCH-1:0] en_d;
    reg sel_q;
    reg sel_d;
    reg [`EIC_EVT_W-1:0] sts_q;
    reg [`EIC_EVT_W-1:0] sts_d;
    reg [`EIC_EVT_W-1:0] mask_q;
    reg [`EIC_EVT_W-1:0] mask_d;
    reg [`EIC_DATA_W-1:0] rdata_d;

    wire [NCH-1:0] pins_w;
    wire [NCH-1:0] edge_w;
    wire [CNT_W*NCH-1:0] cnt_w;
    wire [`EIC_EVT_W-1:0] evt_w;

    // The non-maskable input sits on the top channel so that one synchroniser
    // serves both the non-maskable path and interrupt thirteen.
    assign pins_w = {ext_nonmaskable_irq_i, ext_irq_channel_i};
    assign evt_w = edge_w;

    // ======================================================================
    // Channels
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_chan
            eic_channel #(
                .CNT_W(CNT_W)
            ) u_chan (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .pin_i(pins_w[g]),
                .en_i(en_q[g]),
                .pol_i(pol_q[2*g+1:2*g]),
                .edge_o(edge_w[g]),
                .cnt_o(cnt_w[CNT_W*g+CNT_W-1:CNT_W*g])
            );
        end
    endgenerate

    // ======================================================================
    // Register writes
    integer k;

    always @* begin
        pol_d = pol_q;
        en_d = en_q;
        sel_d = sel_q;
        mask_d = mask_q;
        sts_d = sts_q;
        if (reg_wr_i) begin
            for (k = 0; k < NUM_CHAN; k = k + 1) begin
                if (reg_addr_i == ctrl_addr(k)) begin
                    pol_d[2*k+1 -: 2] = reg_wdata_i[`EIC_POL_HI:`EIC_POL_LO];
                    en_d[k] = reg_wdata_i[`EIC_EN_BIT];
                end
            end
            if (reg_addr_i == `EIC_NMI_CTRL_ADDR) begin
                pol_d[2*NMI+1 -: 2] = reg_wdata_i[`EIC_POL_HI:`EIC_POL_LO];
                en_d[NMI] = reg_wdata_i[`EIC_EN_BIT];
                sel_d = reg_wdata_i[`EIC_SEL_BIT];
            end
            if (reg_addr_i == `EIC_MASK_ADDR) begin
                mask_d = reg_wdata_i[`EIC_EVT_W-1:0];
            end
            if (reg_addr_i == `EIC_STATUS_ADDR) begin
                sts_d = sts_q & ~reg_wdata_i[`EIC_EVT_W-1:0];
            end
        end
        // A new event in the clearing cycle survives the clear.
        sts_d = sts_d | evt_w;
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            pol_q <= {(2*NCH){1'b0}};
            en_q <= {NCH{1'b0}};
            sel_q <= 1'b0;
            mask_q <= `EIC_MASK_RST;
            sts_q <= `EIC_STATUS_RST;
        end else begin
            pol_q <= pol_d;
            en_q <= en_d;
            sel_q <= sel_d;
            mask_q <= mask_d;
            sts_q <= sts_d;
        end
    end

    // ======================================================================
    // Register reads
    // Counters have no write path at all; only an edge or reset clears them.
    // The read loop has its own index so that no variable has two drivers.
    integer j;

    always @* begin
        rdata_d = `EIC_RDATA_RST;
        for (j = 0; j < NUM_CHAN; j = j + 1) begin
            if (reg_addr_i == ctrl_addr(j)) begin
                rdata_d = fmt_ctrl(pol_q[2*j+1 -: 2], en_q[j], 1'b0);
            end
            if (reg_addr_i == cnt_addr(j)) begin
                rdata_d = cnt_w[CNT_W*j +: CNT_W];
            end
        end
        if (reg_addr_i == `EIC_NMI_CTRL_ADDR) begin
            rdata_d = fmt_ctrl(pol_q[2*NMI+1 -: 2], en_q[NMI], sel_q);
        end
        if (reg_addr_i == `EIC_NMI_CNT_ADDR) begin
            rdata_d = cnt_w[CNT_W*NMI +: CNT_W];
        end
        if (reg_addr_i == `EIC_STATUS_ADDR) begin
            rdata_d[`EIC_EVT_W-1:0] = sts_q;
        end
        if (reg_addr_i == `EIC_MASK_ADDR) begin
            rdata_d[`EIC_EVT_W-1:0] = mask_q;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= `EIC_RDATA_RST;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= `EIC_RDATA_RST;
        end
    end

    // ======================================================================
    // CPU interrupt outputs
    // With the select bit set the pin feeds interrupt thirteen instead of the
    // non-maskable line, so one edge never reaches both.
    always @(posedge clk_i) begin
        if (srst_i) begin
            ext_irq_channel_o <= {NUM_CHAN{1'b0}};
            ext_nonmaskable_irq_o <= 1'b0;
            cpu_irq_thirteen_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            ext_irq_channel_o <= edge_w[NUM_CHAN-1:0];
            ext_nonmaskable_irq_o <= edge_w[NMI] & ~sel_q;
            if (sel_q) begin
                cpu_irq_thirteen_o <= edge_w[NMI];
            end else begin
                cpu_irq_thirteen_o <= timer1_irq_i;
            end
            irq_o <= |(sts_d & mask_d);
        end
    end

endmodule // eic_ctrl

`default_nettype wire

//--- verilog/eic_defines.vh
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH

// ==========================================================================
// Register bus geometry
`define EIC_ADDR_W 16
`define EIC_DATA_W 16
`define EIC_CNT_W 16
`define EIC_NUM_CHAN 7

// ==========================================================================
// Register offsets (word addresses on the register port)
`define EIC_CTRL_BASE 16'h7060
`define EIC_NMI_CTRL_ADDR 16'h7077
`define EIC_CNT1_ADDR 16'h7078
`define EIC_CNT2_ADDR 16'h7079
`define EIC_CNT_BASE 16'h7068
`define EIC_NMI_CNT_ADDR 16'h707F
`define EIC_STATUS_ADDR 16'h7080
`define EIC_MASK_ADDR 16'h7081

// ==========================================================================
// Control register fields
`define EIC_EN_BIT 0
`define EIC_SEL_BIT 1
`define EIC_POL_LO 2
`define EIC_POL_HI 3
`define EIC_POL_FALL_A 2'h0
`define EIC_POL_RISE 2'h1
`define EIC_POL_FALL_B 2'h2
`define EIC_POL_BOTH 2'h3

// ==========================================================================
// Reset values
`define EIC_CTRL_RST 16'h0000
`define EIC_CNT_RST 16'h0000
`define EIC_STATUS_RST 8'h00
`define EIC_MASK_RST 8'h00
`define EIC_RDATA_RST 16'h0000

// ==========================================================================
// Status and mask layout: bits 6..0 are channels 7..1, bit 7 the non-maskable input
`define EIC_NMI_IDX 7
`define EIC_EVT_W 8

`endif
